// ### include/sop_pkg.sv
package sop_pkg;
    localparam int AXI_AW = 12;
    // Register indices; byte address is four times the index
    localparam logic [11:0] IDX_CPU_MODE = 12'h0FB;
    localparam logic [11:0] IDX_CLK_SRC = 12'h216;
    localparam logic [11:0] IDX_PWR_CTL = 12'h0F0;
    localparam logic [11:0] ADDR_CPU_MODE = 12'h3EC;
    localparam logic [11:0] ADDR_CLK_SRC = 12'h858;
    localparam logic [11:0] ADDR_PWR_CTL = 12'h3C0;
    // CPU mode register fields
    localparam int CM_LOW_SPEED_BIT = 7;
    localparam int CM_MAIN_STOP_BIT = 6;
    localparam int CM_SUB_DRIVE_BIT = 5;
    localparam logic [7:0] CPU_MODE_RESET = 8'h20;
    // Clock source control fields
    localparam int CS_SEL_LO = 4;
    localparam int CS_SEL_HI = 5;
    localparam logic [7:0] CLK_SRC_RESET = 8'h00;
    // Power control: write bits are commands, read bits are status
    localparam int PC_STOP_BIT = 0;
    localparam int PC_WAIT_BIT = 1;
    localparam int PC_STATE_LO = 0;
    localparam int PC_MAIN_RUN_BIT = 4;
    localparam int PC_SUB_RUN_BIT = 5;
    localparam int PC_PHI_BIT = 6;
    localparam int PC_SRC_SUB_BIT = 7;
    // Stop-mode delay timers
    localparam logic [7:0] T3_PRELOAD = 8'hFF;
    localparam logic [7:0] T4_PRELOAD = 8'h07;
    localparam logic [3:0] PRESCALE_LAST = 4'hF;
    // Wake sources seen by wait mode
    localparam int WAKE_W = 16;
    localparam logic [15:0] WAIT_BLOCK_MASK = 16'hFFC0;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    typedef enum logic [2:0] {
        SOP_RUN,
        SOP_WAIT,
        SOP_STOP_HALT,
        SOP_STOP_STAB
    } sop_state_t;
endpackage : sop_pkg

// ### hdl/sop_sync.sv
`timescale 1ns/1ps
module sop_sync #(
    parameter int W = 1
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            meta_q <= '0;
            sync_o <= '0;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : sop_sync

// ### hdl/sop_timer.sv
`timescale 1ns/1ps
// Down counter, reload on underflow: period is preload + 1 ticks
module sop_timer (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [7:0] preload_i,
    input wire logic tick_i,
    output logic ovf_o
);
    logic [7:0] count_q;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            count_q <= '0;
            ovf_o <= 1'b0;
        end else if (load_i) begin
            count_q <= preload_i;
            ovf_o <= 1'b0;
        end else begin
            ovf_o <= tick_i && (count_q == 8'h00);
            if (tick_i) begin
                count_q <= (count_q == 8'h00) ? preload_i : count_q - 8'h01;
            end
        end
    end
endmodule : sop_timer

// ### hdl/sop_clock_ctrl.sv
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
module sop_clock_ctrl (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // AXI4-Lite slave
    input wire logic [sop_pkg::AXI_AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [sop_pkg::AXI_AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Oscillator pins and wake sources
    input wire logic main_osc_input_i,
    input wire logic sub_osc_input_i,
    input wire logic display_osc_input_i,
    input wire logic ext_int_i,
    input wire logic [sop_pkg::WAKE_W-1:0] wake_req_i,
    // Clock outputs and oscillator controls
    output logic phi_o,
    output logic main_osc_en_o,
    output logic sub_osc_en_o,
    output logic sub_osc_drive_o,
    output logic display_clk_o,
    output logic halted_o
);
    import sop_pkg::*;

    sop_state_t state_q;
    logic [7:0] cpu_mode_q;
    logic [7:0] clk_src_q;
    logic cmd_stop_q;
    logic cmd_wait_q;
    logic [3:0] pins_sync;
    logic main_prev_q;
    logic sub_prev_q;
    logic tick_main;
    logic tick_sub;
    logic tick_src;
    logic src_sub_q;
    logic req_sub;
    logic phi_q;
    logic gated_q;
    logic halt_req;
    logic [3:0] prescale_q;
    logic tick16_q;
    logic timer_load;
    logic t3_ovf;
    logic t4_ovf;
    logic ext_int_sync;
    logic wait_wake;
    logic [AXI_AW-1:0] awaddr_q;
    logic aw_got_q;
    logic [7:0] wdata_q;
    logic wstrb0_q;
    logic w_got_q;
    logic wr_fire;
    logic [31:0] rd_word;
    logic rd_hit;

    sop_sync #(.W(4)) u_pin_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .async_i({ext_int_i, display_osc_input_i, sub_osc_input_i, main_osc_input_i}),
        .sync_o(pins_sync)
    );

    assign ext_int_sync = pins_sync[3];
    assign tick_main = pins_sync[0] && !main_prev_q;
    assign tick_sub = pins_sync[1] && !sub_prev_q;
    assign tick_src = src_sub_q ? tick_sub : tick_main;
    // Main stop forces the sub-clock even if the speed bit is still clear
    assign req_sub = cpu_mode_q[CM_LOW_SPEED_BIT] || cpu_mode_q[CM_MAIN_STOP_BIT];
    assign halt_req = (state_q != SOP_RUN);
    assign wait_wake = |(wake_req_i & ~WAIT_BLOCK_MASK);
    assign timer_load = cmd_stop_q && (state_q == SOP_RUN);

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            main_prev_q <= 1'b0;
            sub_prev_q <= 1'b0;
        end else begin
            main_prev_q <= pins_sync[0];
            sub_prev_q <= pins_sync[1];
        end
    end

    // Internal clock: toggles on each source rising edge, so each level lasts
    // a full source period; switching and gating only happen with phi high
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            phi_q <= 1'b1;
            gated_q <= 1'b0;
            src_sub_q <= 1'b0;
        end else if (req_sub != src_sub_q) begin
            if (phi_q && (req_sub ? tick_sub : tick_main)) begin
                src_sub_q <= req_sub;
            end else if (!phi_q && tick_src) begin
                phi_q <= 1'b1;
            end
        end else if (tick_src) begin
            if (halt_req && phi_q) begin
                gated_q <= 1'b1;
            end else if (!halt_req && gated_q) begin
                gated_q <= 1'b0;
            end else if (!gated_q) begin
                phi_q <= !phi_q;
            end
        end
    end

    // Oscillator / 16 count source for timer 3
    // Held clear outside stabilisation so the delay counts from the restart
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || (state_q != SOP_STOP_STAB)) begin
            prescale_q <= '0;
            tick16_q <= 1'b0;
        end else begin
            tick16_q <= tick_src && (prescale_q == PRESCALE_LAST) && (state_q == SOP_STOP_STAB);
            if (tick_src) begin
                prescale_q <= prescale_q + 4'h1;
            end
        end
    end

    // Timer 3 chained into timer 4; 16 x 256 x 8 source cycles of delay
    sop_timer u_timer3 (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .load_i(timer_load),
        .preload_i(T3_PRELOAD),
        .tick_i(tick16_q),
        .ovf_o(t3_ovf)
    );

    sop_timer u_timer4 (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .load_i(timer_load),
        .preload_i(T4_PRELOAD),
        .tick_i(t3_ovf),
        .ovf_o(t4_ovf)
    );

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_q <= SOP_RUN;
        end else begin
            unique case (state_q)
                SOP_RUN: begin
                    if (cmd_stop_q) begin
                        state_q <= SOP_STOP_HALT;
                    end else if (cmd_wait_q) begin
                        state_q <= SOP_WAIT;
                    end
                end
                SOP_WAIT: begin
                    if (wait_wake) begin
                        state_q <= SOP_RUN;
                    end
                end
                SOP_STOP_HALT: begin
                    if (ext_int_sync && gated_q) begin
                        state_q <= SOP_STOP_STAB;
                    end
                end
                SOP_STOP_STAB: begin
                    if (t4_ovf) begin
                        state_q <= SOP_RUN;
                    end
                end
                default: state_q <= SOP_RUN;
            endcase
        end
    end

    // Oscillators: off while the clock is parked high in stop halt, on again for stabilisation; main also off while main stop is set
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            main_osc_en_o <= 1'b1;
            sub_osc_en_o <= 1'b1;
            sub_osc_drive_o <= 1'b1;
            phi_o <= 1'b1;
            halted_o <= 1'b0;
            display_clk_o <= 1'b0;
        end else begin
            main_osc_en_o <= !cpu_mode_q[CM_MAIN_STOP_BIT] && !((state_q == SOP_STOP_HALT) && gated_q);
            sub_osc_en_o <= !((state_q == SOP_STOP_HALT) && gated_q);
            sub_osc_drive_o <= cpu_mode_q[CM_SUB_DRIVE_BIT];
            phi_o <= phi_q;
            halted_o <= gated_q;
            // Plain mux: software should change the source with display idle
            display_clk_o <= (clk_src_q[CS_SEL_HI:CS_SEL_LO] == 2'b00) ? pins_sync[1] : pins_sync[2];
        end
    end

    // AXI4-Lite write side
    assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= AXI_OKAY;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awaddr_q <= s_axi_awaddr;
                aw_got_q <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wdata_q <= s_axi_wdata[7:0];
                wstrb0_q <= s_axi_wstrb[0];
                w_got_q <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (awaddr_q == ADDR_CPU_MODE || awaddr_q == ADDR_CLK_SRC ||
                                awaddr_q == ADDR_PWR_CTL) ? AXI_OKAY : AXI_SLVERR;
                aw_got_q <= 1'b0;
                w_got_q <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // Register stores and one-cycle instruction strobes
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            cpu_mode_q <= CPU_MODE_RESET;
            clk_src_q <= CLK_SRC_RESET;
            cmd_stop_q <= 1'b0;
            cmd_wait_q <= 1'b0;
        end else begin
            cmd_stop_q <= 1'b0;
            cmd_wait_q <= 1'b0;
            if (wr_fire && wstrb0_q) begin
                if (awaddr_q == ADDR_CPU_MODE) begin
                    cpu_mode_q <= wdata_q & 8'hE0;
                end else if (awaddr_q == ADDR_CLK_SRC) begin
                    clk_src_q <= wdata_q & 8'h30;
                end else if (awaddr_q == ADDR_PWR_CTL) begin
                    cmd_stop_q <= wdata_q[PC_STOP_BIT];
                    cmd_wait_q <= wdata_q[PC_WAIT_BIT] && !wdata_q[PC_STOP_BIT];
                end
            end
        end
    end

    // AXI4-Lite read side
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_hit = 1'b1;
        if (s_axi_araddr == ADDR_CPU_MODE) begin
            rd_word[7:0] = cpu_mode_q;
        end else if (s_axi_araddr == ADDR_CLK_SRC) begin
            rd_word[7:0] = clk_src_q;
        end else if (s_axi_araddr == ADDR_PWR_CTL) begin
            rd_word[PC_STATE_LO+2:PC_STATE_LO] = state_q;
            rd_word[PC_MAIN_RUN_BIT] = main_osc_en_o;
            rd_word[PC_SUB_RUN_BIT] = sub_osc_en_o;
            rd_word[PC_PHI_BIT] = phi_q;
            rd_word[PC_SRC_SUB_BIT] = src_sub_q;
        end else begin
            rd_hit = 1'b0;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= AXI_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_hit ? AXI_OKAY : AXI_SLVERR;
                s_axi_rvalid <= 1'b1;
                s_axi_arready <= 1'b0;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end
    end
endmodule : sop_clock_ctrl

// ### testbench/sop_clock_ctrl_sva.sv
`timescale 1ns/1ps
module sop_clock_ctrl_sva (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic phi_o,
    input wire logic main_osc_en_o,
    input wire logic sub_osc_en_o,
    input wire logic sub_osc_drive_o,
    input wire logic halted_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence rd_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence reset_idle;
        phi_o && main_osc_en_o && sub_osc_en_o && sub_osc_drive_o && !halted_o;
    endsequence
    // Response is registered from both captures, so it shows two cycles later
    chk_wr_answer: assert property (wr_take |-> ##2 s_axi_bvalid)
        else $error("write response missing");
    chk_rd_answer: assert property (rd_take |=> s_axi_rvalid)
        else $error("read response missing");
    chk_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    chk_wr_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    chk_reset_state: assert property ($fell(rst_i) |-> reset_idle)
        else $error("wrong state after reset");
    chk_halt_high: assert property (halted_o |-> phi_o)
        else $error("gated clock not high");
    chk_stop_osc: assert property ($fell(sub_osc_en_o) |-> halted_o)
        else $error("oscillator stopped while running");
    // Bench keeps source half periods at three or more cycles while phi runs
    chk_phi_pulse: assert property ($changed(phi_o) |=> $stable(phi_o) [*2])
        else $error("short internal clock pulse");
endmodule : sop_clock_ctrl_sva

bind sop_clock_ctrl sop_clock_ctrl_sva i_chk (.clk_sys_i, .rst_i, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rvalid, .s_axi_rready, .phi_o, .main_osc_en_o, .sub_osc_en_o, .sub_osc_drive_o, .halted_o);

// ### testbench/sop_clock_ctrl_tb.sv
`timescale 1ns/1ps
module sop_clock_ctrl_tb;
    import sop_pkg::*;
    logic clk_sys_i = 1'h0;
    logic rst_i = 1'h1;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0, s_axi_arvalid = '0, s_axi_rready = '0;
    logic main_osc_input_i = '0, sub_osc_input_i = '0, display_osc_input_i = '0, ext_int_i = '0;
    logic [15:0] wake_req_i = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, phi_o, main_osc_en_o;
    logic sub_osc_en_o, sub_osc_drive_o, display_clk_o, halted_o;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, d;
    logic [1:0] r;
    int n_fail = 0, cmp_count = 0, mc = 0, sc = 0, dc = 0, n, k;
    bit fast = 1'h0;

    sop_clock_ctrl i_dut (.clk_sys_i, .rst_i, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .main_osc_input_i, .sub_osc_input_i, .display_osc_input_i, .ext_int_i, .wake_req_i, .phi_o,
        .main_osc_en_o, .sub_osc_en_o, .sub_osc_drive_o, .display_clk_o, .halted_o);

    always #20 clk_sys_i = ~clk_sys_i;

    // Half periods 3, 11 and 4 cycles; a disabled oscillator freezes
    // Main toggles every cycle while fast, only with phi parked in stop
    always @(posedge clk_sys_i) begin
        mc <= (mc == 2) ? 0 : mc + 1;
        sc <= (sc == 10) ? 0 : sc + 1;
        dc <= (dc == 3) ? 0 : dc + 1;
        if ((mc == 2 || fast) && main_osc_en_o !== 1'h0) main_osc_input_i <= ~main_osc_input_i;
        if (sc == 10 && sub_osc_en_o !== 1'h0) sub_osc_input_i <= ~sub_osc_input_i;
        if (dc == 3) display_osc_input_i <= ~display_osc_input_i;
    end

    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic guard(input int i, input int lim);
        if (i >= lim) begin
            n_fail++;
            end_of_test();
        end
    endtask : guard

    task automatic cyc(input int c);
        repeat (c) @(posedge clk_sys_i);
    endtask : cyc

    task automatic wr(input logic [11:0] a, input logic [7:0] v, input logic [3:0] s, input logic [1:0] er);
        int i;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, v};
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys_i);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
            if (s_axi_bvalid) break;
        end
        guard(i, 50);
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'h0;
        @(posedge clk_sys_i);
    endtask : wr

    task automatic rd(input logic [11:0] a);
        int i;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys_i);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
            if (s_axi_rvalid) break;
        end
        guard(i, 50);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        @(posedge clk_sys_i);
    endtask : rd

    task automatic wait_halt(input logic v, input int lim);
        int i;
        for (i = 0; i < lim && halted_o !== v; i++) @(posedge clk_sys_i);
        guard(i, lim);
    endtask : wait_halt

    // Rising edges of phi or of the display clock over 440 cycles
    task automatic rises(input bit disp, output int cnt);
        logic p, c;
        cnt = 0;
        p = disp ? display_clk_o : phi_o;
        repeat (440) begin
            @(posedge clk_sys_i);
            c = disp ? display_clk_o : phi_o;
            if (c === 1'h1 && p === 1'h0) cnt++;
            p = c;
        end
    endtask : rises

    task automatic t_reset();
        rd(ADDR_CPU_MODE);
        chk(d, {24'h0, CPU_MODE_RESET});
        rd(ADDR_CLK_SRC);
        chk(d, {24'h0, CLK_SRC_RESET});
        rd(ADDR_PWR_CTL);
        chk(d & 32'hBF, 32'h30);
        rises(0, n);
        chk(n >= 35 && n <= 37, 1);
    endtask : t_reset

    task automatic t_bus();
        wr(12'h004, 8'h30, 4'hF, AXI_SLVERR);
        rd(12'h004);
        chk(d, 32'h0);
        chk(r, AXI_SLVERR);
        wr(ADDR_CLK_SRC, 8'h30, 4'h0, AXI_OKAY);
        rd(ADDR_CLK_SRC);
        chk(d, 32'h0);
    endtask : t_bus

    task automatic t_display();
        for (k = 3; k >= 0; k--) begin
            wr(ADDR_CLK_SRC, 8'(k << 4), 4'hF, AXI_OKAY);
            cyc(8);
            rises(1, n);
            chk((k == 0) ? (n >= 19 && n <= 21) : (n >= 54 && n <= 56), 1);
        end
    endtask : t_display

    task automatic t_wait();
        for (k = 0; k < 6; k++) begin
            wr(ADDR_PWR_CTL, 8'h02, 4'hF, AXI_OKAY);
            wait_halt(1, 20);
            cyc(2);
            chk({phi_o, main_osc_en_o, sub_osc_en_o}, 3'h7);
            for (n = 6; n < 16 && k == 0; n++) begin
                wake_req_i <= 16'(1 << n);
                cyc(4);
                chk(halted_o, 1);
            end
            wake_req_i <= 16'(1 << k);
            wait_halt(0, 16);
            chk(halted_o, 0);
            wake_req_i <= '0;
            cyc(1);
        end
    endtask : t_wait

    task automatic t_low_speed();
        wr(ADDR_CPU_MODE, 8'hA0, 4'hF, AXI_OKAY);
        cyc(100);
        rd(ADDR_PWR_CTL);
        chk(d[7], 1);
        rises(0, n);
        chk(n >= 9 && n <= 11, 1);
        wr(ADDR_CPU_MODE, 8'hDF, 4'hF, AXI_OKAY);
        cyc(100);
        rd(ADDR_CPU_MODE);
        chk(d, 32'hC0);
        chk({main_osc_en_o, sub_osc_drive_o}, 2'h0);
        rises(0, n);
        chk(n >= 9 && n <= 11, 1);
        wr(ADDR_CPU_MODE, 8'hA0, 4'hF, AXI_OKAY);
        chk(main_osc_en_o, 1);
        cyc(1000);
        wr(ADDR_CPU_MODE, 8'h20, 4'hF, AXI_OKAY);
        cyc(100);
    endtask : t_low_speed

    // Timer sources and interrupt enables live outside this block
    task automatic t_stop();
        int i;
        logic p;
        wr(ADDR_CPU_MODE, 8'h20, 4'hF, AXI_OKAY);
        // Wake lines held low: timer interrupts disabled, timer 3 on oscillator/16
        wr(ADDR_PWR_CTL, 8'h01, 4'hF, AXI_OKAY);
        wait_halt(1, 40);
        cyc(4);
        chk({phi_o, main_osc_en_o, sub_osc_en_o}, 3'h4);
        ext_int_i <= 1'h1;
        n = 0;
        p = main_osc_input_i;
        for (i = 0; i < 80000 && halted_o !== 1'h0; i++) begin
            @(posedge clk_sys_i);
            if (main_osc_input_i && !p) n++;
            p = main_osc_input_i;
            if (main_osc_en_o) ext_int_i <= 1'h0;
            // Fast source keeps the run short; slow again well before phi restarts
            fast <= (n < 32700);
        end
        guard(i, 80000);
        chk(n >= 32768 && n <= 32772, 1);
        rises(0, n);
        chk(n >= 35 && n <= 37, 1);
    endtask : t_stop

    initial begin
        repeat (16) @(posedge clk_sys_i);
        rst_i <= 1'h0;
        t_reset();
        t_bus();
        t_display();
        t_wait();
        t_low_speed();
        t_stop();
        end_of_test();
    end
endmodule : sop_clock_ctrl_tb
